// *** design/serial_defs.vh ***
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH
// master clock rate and derived times
`define CLK_HZ              25000000
`define RESTORE_HOLD_MS     450
`define RESTORE_HOLD_CYC    (`CLK_HZ / 1000 * `RESTORE_HOLD_MS)
`define RESET_PULSE_US      20
`define RESET_PULSE_CYC     (`CLK_HZ / 1000000 * `RESET_PULSE_US)
// serial format
`define BAUD_DIV            16'd217
`define BAUD_HALF           16'd108
`define FIFO_WIDTH          8
`define FIFO_DEPTH          16
`define FIFO_AW             4
// configuration image
`define CFG_WORDS           8
`define CFG_AW              3
`define CFG_FACTORY         8'h00
`endif

// *** design/byte_fifo.v ***
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  input  wire             ce,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg             have_q;
  wire [AW:0]     count = wr_q - rd_q;
  wire            empty = (count == {(AW+1){1'b0}});
  wire            pop   = have_q && out_ready;
  wire            fetch = !empty && (!have_q || pop);

  // depth is a power of two, so the top count bit marks full
  assign in_ready  = !count[AW];
  assign out_valid = have_q;

  always @(posedge mclk)
  begin
    if (ce && in_valid && in_ready)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // read data leaves from a register
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q     <= {(AW+1){1'b0}};
      rd_q     <= {(AW+1){1'b0}};
      have_q   <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (fetch)
      begin
        out_data <= mem[rd_q[AW-1:0]];
        rd_q     <= rd_q + 1'b1;
        have_q   <= 1'b1;
      end
      else if (pop)
        have_q <= 1'b0;
    end
  end
endmodule

// *** design/serial_mode_port.v ***
// Operation
// RQ1 - clear-to-send low while bytes can be accepted
// RQ2 - host pauses while clear-to-send is high
// RQ3 - command-select low makes bytes register commands
// RQ4 - command-select high passes bytes through transparently
// RQ5 - command-select low at reset restores factory defaults
// RQ6 - host keeps command-select high at power-up
// RQ7 - host holds command-select low 450 ms
// RQ8 - every reset loads working copies from stored
// RQ9 - reset pin held low at least 20 us
`timescale 1ns/1ps
`include "serial_defs.vh"
module serial_mode_port #(
  parameter RESTORE_CYC = `RESTORE_HOLD_CYC
) (
  // clock, reset, enable
  input  wire       mclk,
  input  wire       rstn,
  input  wire       ce,
  // host pins
  input  wire       rxd,
  output reg        txd,
  output reg        cts_n,
  input  wire       cmd_n,
  // link side
  output reg  [7:0] link_tx_data,
  output reg        link_tx_valid,
  input  wire       link_tx_ready,
  input  wire [7:0] link_rx_data,
  input  wire       link_rx_valid,
  output reg        link_rx_ready,
  // command side
  output reg  [7:0] cmd_byte,
  output reg        cmd_valid,
  // status
  output reg        restore_done,
  output reg        cfg_loaded
);
  localparam ST_LOAD  = 2'd0;
  localparam ST_RUN   = 2'd1;
  localparam RX_IDLE  = 2'd0;
  localparam RX_DATA  = 2'd1;
  localparam RX_STOP  = 2'd2;
  localparam RX_START = 2'd3;

  reg [1:0]  rs_q;
  wire       rst_n = rs_q[1];
  reg [2:0]  rx_s_q;
  reg [2:0]  cmd_s_q;
  reg        rx_f_q;
  reg        cmd_f_q;
  // working and stored images; stored sits in registers, kept small
  reg [7:0]  nv_q   [0:`CFG_WORDS-1];
  reg [7:0]  work_q [0:`CFG_WORDS-1];
  reg [1:0]  st_q;
  reg [`CFG_AW:0] ld_q;
  reg        strap_q;
  reg        strap_seen_q;
  reg [2:0]  settle_q;
  reg [4:0]  occ_q;
  reg [31:0] hold_q;
  reg [1:0]  rst_q;
  reg [15:0] rbaud_q;
  reg [2:0]  rbit_q;
  reg [7:0]  rsh_q;
  reg        rvalid_q;
  reg [15:0] tbaud_q;
  reg [3:0]  tbit_q;
  reg [9:0]  tsh_q;
  wire       f_in_ready;
  wire       f_out_valid;
  wire [7:0] f_out_data;
  reg        f_out_ready;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rs_q <= 2'b00;
    else
      rs_q <= {rs_q[0], 1'b1};
  end

  // pins pass three stages, change taken when last two agree
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s_q  <= 3'b111;
      cmd_s_q <= 3'b111;
      rx_f_q  <= 1'b1;
      cmd_f_q <= 1'b1;
    end
    else if (ce)
    begin
      rx_s_q  <= {rx_s_q[1:0], rxd};
      cmd_s_q <= {cmd_s_q[1:0], cmd_n};
      if (rx_s_q[2] == rx_s_q[1])
        rx_f_q <= rx_s_q[2];
      if (cmd_s_q[2] == cmd_s_q[1])
        cmd_f_q <= cmd_s_q[2];
    end
  end

  // byte receiver
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q    <= RX_IDLE;
      rbaud_q  <= 16'h0000;
      rbit_q   <= 3'h0;
      rsh_q    <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_q <= 1'b0;
      case (rst_q)
        RX_IDLE:
          if (!rx_f_q && st_q == ST_RUN)
          begin
            rbaud_q <= `BAUD_HALF;
            rbit_q  <= 3'h0;
            rst_q   <= RX_START;
          end
        // start bit checked at mid-bit, glitches drop back to idle
        RX_START:
          if (rbaud_q == 16'h0000)
          begin
            rbaud_q <= `BAUD_DIV - 16'd1;
            if (!rx_f_q)
              rst_q <= RX_DATA;
            else
              rst_q <= RX_IDLE;
          end
          else
            rbaud_q <= rbaud_q - 16'h0001;
        RX_DATA:
          if (rbaud_q == 16'h0000)
          begin
            rbaud_q <= `BAUD_DIV - 16'd1;
            rsh_q  <= {rx_f_q, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == 3'h7)
              rst_q <= RX_STOP;
          end
          else
            rbaud_q <= rbaud_q - 16'h0001;
        RX_STOP:
          if (rbaud_q == 16'h0000)
          begin
            if (rx_f_q)
              rvalid_q <= 1'b1;
            rst_q <= RX_IDLE;
          end
          else
            rbaud_q <= rbaud_q - 16'h0001;
        default:
          rst_q <= RX_IDLE;
      endcase
    end
  end

  // reset sampling of command-select, restore and load
  always @(posedge mclk or negedge rst_n)
  begin : cfg_blk
    integer i;
    if (!rst_n)
    begin
      st_q         <= ST_LOAD;
      ld_q         <= {(`CFG_AW+1){1'b0}};
      strap_q      <= 1'b0;
      strap_seen_q <= 1'b0;
      settle_q     <= 3'h0;
      hold_q       <= 32'h00000000;
      restore_done <= 1'b0;
      cfg_loaded   <= 1'b0;
      for (i = 0; i < `CFG_WORDS; i = i + 1)
        work_q[i] <= `CFG_FACTORY;
    end
    else if (ce)
    begin
      // synchroniser holds its reset value for a few cycles
      if (!strap_seen_q)
      begin
        if (settle_q == 3'h4)
        begin
          strap_seen_q <= 1'b1;
          // RQ5 strap caught after release
          strap_q      <= !cmd_f_q;
        end
        else
          settle_q <= settle_q + 3'h1;
      end
      if (strap_q && !restore_done)
      begin
        if (cmd_f_q)
        begin
          // RQ5 restore factory on release
          if (hold_q >= RESTORE_CYC)
          begin
            for (i = 0; i < `CFG_WORDS; i = i + 1)
              nv_q[i] <= `CFG_FACTORY;
            restore_done <= 1'b1;
          end
          strap_q <= 1'b0;
        end
        else if (hold_q < RESTORE_CYC)
          hold_q <= hold_q + 32'h00000001;
      end
      if (st_q == ST_LOAD && strap_seen_q && !strap_q)
      begin
        // RQ8 working copies from stored
        if (ld_q == `CFG_WORDS)
        begin
          st_q       <= ST_RUN;
          cfg_loaded <= 1'b1;
        end
        else
        begin
          work_q[ld_q[`CFG_AW-1:0]] <= nv_q[ld_q[`CFG_AW-1:0]];
          ld_q <= ld_q + 1'b1;
        end
      end
    end
  end

  // RQ3 RQ4 route each received byte by mode
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_byte  <= 8'h00;
      cmd_valid <= 1'b0;
    end
    else if (ce)
    begin
      cmd_valid <= rvalid_q && !cmd_f_q;
      if (rvalid_q && !cmd_f_q)
        cmd_byte <= rsh_q;
    end
  end

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (rvalid_q && cmd_f_q),
    .in_ready  (f_in_ready),
    .in_data   (rsh_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always @*
  begin
    f_out_ready = !link_tx_valid || link_tx_ready;
  end

  // link output stage and flow control
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_tx_data  <= 8'h00;
      link_tx_valid <= 1'b0;
      cts_n         <= 1'b1;
      occ_q         <= 5'h00;
    end
    else if (ce)
    begin
      // bytes held in the fifo, its output register included
      occ_q <= occ_q + {4'h0, rvalid_q && cmd_f_q && f_in_ready}
                     - {4'h0, f_out_valid && f_out_ready};
      if (f_out_valid && f_out_ready)
      begin
        link_tx_data  <= f_out_data;
        link_tx_valid <= 1'b1;
      end
      else if (link_tx_ready)
        link_tx_valid <= 1'b0;
      // RQ1 pause host near full
      // three-byte margin covers synchroniser and a byte in flight
      cts_n <= !(st_q == ST_RUN && f_in_ready && (occ_q < 5'd14));
    end
  end

  // RQ4 peer data out on transmit line
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txd           <= 1'b1;
      tbaud_q       <= 16'h0000;
      tbit_q        <= 4'h0;
      tsh_q         <= 10'h3ff;
      link_rx_ready <= 1'b0;
    end
    else if (ce)
    begin
      link_rx_ready <= 1'b0;
      if (tbit_q == 4'h0)
      begin
        if (link_rx_valid && !link_rx_ready && st_q == ST_RUN)
        begin
          tsh_q         <= {1'b1, link_rx_data, 1'b0};
          // eleventh step keeps the stop bit a full bit long
          tbit_q        <= 4'd11;
          tbaud_q       <= 16'h0000;
          link_rx_ready <= 1'b1;
        end
      end
      else if (tbaud_q == 16'h0000)
      begin
        txd     <= tsh_q[0];
        tsh_q   <= {1'b1, tsh_q[9:1]};
        tbit_q  <= tbit_q - 4'h1;
        tbaud_q <= `BAUD_DIV - 16'd1;
      end
      else
        tbaud_q <= tbaud_q - 16'h0001;
    end
  end
endmodule

// *** sim/serial_mode_port_asserts.sv ***
`timescale 1ns/1ps
module serial_mode_port_chk #(
  parameter RESTORE_CYC = 100
) (
  // clock and reset
  input wire       mclk,
  input wire       rstn,
  // watched pins
  input wire       cts_n,
  input wire       cmd_n,
  input wire [7:0] link_tx_data,
  input wire       link_tx_valid,
  input wire       link_tx_ready,
  input wire       cmd_valid,
  input wire       restore_done,
  input wire       cfg_loaded
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  reg [31:0] low_q;
  reg        gone_q;
  sequence rel_s;
    $rose(rstn) && cmd_n;
  endsequence
  // length of the low run since reset, frozen once released
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      low_q  <= 32'h0;
      gone_q <= 1'b0;
    end
    else if (cmd_n)
      gone_q <= 1'b1;
    else if (!gone_q)
      low_q <= low_q + 32'h1;
  load_time_a: assert property (rel_s |-> ##[1:40] cfg_loaded)
    else $error("working copy not loaded");
  cts_load_a: assert property (!cts_n |-> cfg_loaded)
    else $error("clear to send before load");
  cmd_mode_a: assert property (cmd_valid |-> !cmd_n)
    else $error("command byte outside command mode");
  tx_hold_a: assert property (link_tx_valid && !link_tx_ready
    |=> link_tx_valid && $stable(link_tx_data))
    else $error("link byte dropped or changed");
  restore_cnt_a: assert property ($rose(restore_done)
    |-> low_q >= RESTORE_CYC) else $error("restore without long hold");
  restore_keep_a: assert property (restore_done |=> restore_done)
    else $error("restore flag lost");
endmodule
bind serial_mode_port serial_mode_port_chk #(.RESTORE_CYC(RESTORE_CYC)) chk (
  .mclk(mclk), .rstn(rstn), .cts_n(cts_n), .cmd_n(cmd_n),
  .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
  .link_tx_ready(link_tx_ready), .cmd_valid(cmd_valid),
  .restore_done(restore_done), .cfg_loaded(cfg_loaded)
);

// *** sim/host_uart_model.sv ***
`timescale 1ns/1ps
module host_uart_model (
  // clock and flow control
  input  wire mclk,
  input  wire cts_n,
  // serial lines
  output reg  rxd,
  input  wire txd
);
  localparam BIT = 217;
  integer k;
  integer j;
  initial
    rxd = 1'b1;
  task send(input [7:0] b);
  begin
    while (cts_n !== 1'b0)
      @(negedge mclk);
    rxd = 1'b0;
    repeat (BIT) @(negedge mclk);
    for (k = 0; k < 8; k++)
    begin
      rxd = b[k];
      repeat (BIT) @(negedge mclk);
    end
    rxd = 1'b1;
    repeat (BIT) @(negedge mclk);
  end
  endtask
  task recv(output [7:0] b);
  begin
    while (txd !== 1'b0)
      @(negedge mclk);
    // sample in mid-bit
    repeat (BIT + BIT / 2) @(negedge mclk);
    for (j = 0; j < 8; j++)
    begin
      b[j] = txd;
      repeat (BIT) @(negedge mclk);
    end
  end
  endtask
endmodule

// *** sim/serial_mode_port_tb_top.sv ***
`timescale 1ns/1ps
`define CK(n, e, a) comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end
module serial_mode_port_tb_top;
  reg        mclk, rstn, ce, cmd_n, link_tx_ready, link_rx_valid;
  reg  [7:0] link_rx_data, cmd_got, rb;
  wire [7:0] link_tx_data, cmd_byte;
  wire       rxd, txd, cts_n, link_tx_valid, link_rx_ready, cmd_valid;
  wire       restore_done, cfg_loaded;
  reg  [7:0] got[$];
  integer    errors = 0, comparisons = 0, i;
  serial_mode_port #(.RESTORE_CYC(100)) DUT (
    .mclk(mclk), .rstn(rstn), .ce(ce), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .cmd_n(cmd_n), .link_tx_data(link_tx_data),
    .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
    .link_rx_data(link_rx_data), .link_rx_valid(link_rx_valid),
    .link_rx_ready(link_rx_ready), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .restore_done(restore_done),
    .cfg_loaded(cfg_loaded)
  );
  host_uart_model host (.mclk(mclk), .cts_n(cts_n), .rxd(rxd), .txd(txd));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (link_tx_valid === 1'b1 && link_tx_ready === 1'b1)
      got.push_back(link_tx_data);
    if (cmd_valid === 1'b1)
      cmd_got = cmd_byte;
  end
  task do_reset(input c);
  begin
    rstn = 1'b0;
    cmd_n = c;
    repeat (500) @(negedge mclk);
    rstn = 1'b1;
  end
  endtask
  task t_boot;
  begin
    do_reset(1'b1);
    repeat (60) @(negedge mclk);
    `CK("loaded", 1'b1, cfg_loaded)
    `CK("restore", 1'b0, restore_done)
    `CK("cts_n", 1'b0, cts_n)
  end
  endtask
  task t_pass;
  begin
    got.delete();
    host.send(8'ha5);
    repeat (20) @(negedge mclk);
    `CK("pass byte", 8'ha5, got[0])
    link_rx_data = 8'h5a;
    link_rx_valid = 1'b1;
    fork
      host.recv(rb);
      begin
        while (link_rx_ready !== 1'b1)
          @(negedge mclk);
        @(negedge mclk);
        link_rx_valid = 1'b0;
        link_rx_data = 8'ha5;
      end
    join
    `CK("txd byte", 8'h5a, rb)
  end
  endtask
  task t_cmd;
  begin
    got.delete();
    cmd_n = 1'b0;
    host.send(8'h3c);
    repeat (20) @(negedge mclk);
    `CK("cmd byte", 8'h3c, cmd_got)
    `CK("no pass", 0, got.size())
    cmd_n = 1'b1;
  end
  endtask
  task t_full;
  begin
    got.delete();
    link_tx_ready = 1'b0;
    for (i = 0; i < 16 && cts_n !== 1'b1; i++)
      host.send(8'h10 + i[7:0]);
    repeat (20) @(negedge mclk);
    `CK("fill", 1'b1, (i >= 14 && i <= 15 && cts_n === 1'b1))
    link_tx_ready = 1'b1;
    repeat (40) @(negedge mclk);
    `CK("cts_n free", 1'b0, cts_n)
    `CK("drained", i, got.size())
    `CK("last", 8'h0f + i[7:0], got[i - 1])
  end
  endtask
  task t_restore(input integer hold, input exp);
  begin
    do_reset(1'b0);
    repeat (hold) @(negedge mclk);
    cmd_n = 1'b1;
    repeat (40) @(negedge mclk);
    `CK("restore", exp, restore_done)
  end
  endtask
  task end_sim;
  begin
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    ce = 1'b1;
    rstn = 1'b0;
    cmd_n = 1'b1;
    link_tx_ready = 1'b1;
    link_rx_valid = 1'b0;
    link_rx_data = 8'h00;
    t_boot;
    t_pass;
    t_cmd;
    t_full;
    t_restore(150, 1'b1);
    t_restore(60, 1'b0);
    end_sim;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    end_sim;
  end
endmodule
